// >>> verilog/agc_pkg.sv
// constants, field layouts and types for the converter front-end control block
// assumes one system clock; the sfr bus and the converter logic share it
//
// Contract
// RULE_01 - eight gain codes, unity to 128
// RULE_02 - offset trim: sign bit, seven-bit magnitude
// RULE_03 - full trim magnitude equals half input range
// RULE_04 - three-bit calibration command starts calibrations
// RULE_05 - seven periods each; offset-plus-gain takes fourteen
// RULE_06 - system offset: zero input, cancel offset
// RULE_07 - system gain: full-scale input, cancel gain
// RULE_08 - software writes offset trim after calibration
// RULE_09 - calibration done raises converter interrupt flag
// RULE_10 - software recalibrates after power-up or changes
// RULE_11 - fast, sinc2 or sinc3 filter selectable
// RULE_12 - auto: fast twice, then sinc2, then sinc3
// RULE_13 - software discards first result after switch
// RULE_14 - reference internal or external, power-up internal-high
// RULE_15 - internal reference level low or high
// RULE_16 - software disables unused internal reference
// RULE_17 - no normal results while calibration runs
package agc_pkg;

   // register addresses on the special function register bus
   localparam logic [7:0] ADDR_CTRL_ZERO = 8'hDC;
   localparam logic [7:0] ADDR_CTRL_ONE = 8'hDD;
   localparam logic [7:0] ADDR_OFFSET_TRIM = 8'hE6;

   // converter_control_zero fields
   localparam int C0_GAIN_LSB = 0;
   localparam int C0_BUFFER_BIT = 3;
   localparam int C0_REF_HIGH_BIT = 4;
   localparam int C0_REF_INT_EN_BIT = 5;
   localparam int C0_BURNOUT_BIT = 6;
   localparam int C0_REF_EXT_BIT = 7;
   // internal reference, enabled, higher level
   localparam logic [7:0] CTRL_ZERO_RESET = 8'h30;

   // converter_control_one fields
   localparam int C1_CAL_LSB = 0;
   localparam int C1_FILT_LSB = 5;
   localparam int C1_BUSY_BIT = 7;
   localparam logic [7:0] CTRL_ONE_RESET = 8'h00;

   // offset trim fields
   localparam int TRIM_SIGN_BIT = 7;
   localparam logic [7:0] OFFSET_TRIM_RESET = 8'h00;
   // magnitude that shifts the amplifier input by half its full-scale range
   localparam logic [6:0] TRIM_HALF_RANGE_MAG = 7'h7F;

   // calibration timing in conversion periods
   localparam logic [2:0] CAL_PERIODS = 3'h7;
   // conversions on the fast filter after a channel or gain change
   localparam logic [1:0] AUTO_FAST_CONVS = 2'h2;

   localparam logic [23:0] GAIN_CORR_RESET = 24'h7FFFFF;
   localparam logic [23:0] OFS_CORR_RESET = 24'h000000;

   typedef enum logic [2:0] {
      CAL_NONE = 3'h0,
      CAL_SELF_BOTH = 3'h1,
      CAL_SELF_OFS = 3'h2,
      CAL_SELF_GAIN = 3'h3,
      CAL_RSVD_4 = 3'h4,
      CAL_SYS_OFS = 3'h5,
      CAL_SYS_GAIN = 3'h6,
      CAL_RSVD_7 = 3'h7
   } agc_cal_cmd_t;

   typedef enum logic [1:0] {
      FILT_AUTO = 2'h0,
      FILT_FAST = 2'h1,
      FILT_SINC2 = 2'h2,
      FILT_SINC3 = 2'h3
   } agc_filt_t;

   // what the front-end input switches present to the modulator
   typedef enum logic [1:0] {
      CIN_EXTERNAL = 2'h0,
      CIN_SHORTED = 2'h1,
      CIN_REFERENCE = 2'h2
   } agc_cal_in_t;

endpackage

// >>> verilog/agc_cal_if.sv
// signals between the control registers and the calibration sequencer
// assumes both ends run on the same system clock
`timescale 1ns/1ns
`default_nettype none
interface agc_cal_if;
   logic start;
   logic do_offset;
   logic do_gain;
   logic conv_done;
   logic busy;
   logic phase_gain;
   logic capture;
   logic done;

   modport ctl (output start, output do_offset, output do_gain, output conv_done,
      input busy, input phase_gain, input capture, input done);
   modport seq (input start, input do_offset, input do_gain, input conv_done,
      output busy, output phase_gain, output capture, output done);
endinterface
`default_nettype wire

// >>> verilog/agc_cal_seq.sv
// calibration sequencer: counts conversion periods for offset then gain
// assumes conv_done pulses once per conversion period on the system clock
`timescale 1ns/1ns
`default_nettype none
module agc_cal_seq
   import agc_pkg::*;
(
   // clock and reset
   input wire logic clock,
   input wire logic reset_n,
   // control side
   agc_cal_if.seq cal
);

   typedef enum logic [1:0] {
      SEQ_IDLE,
      SEQ_OFFSET,
      SEQ_GAIN
   } agc_seq_state_t;

   agc_seq_state_t state_q;
   logic [2:0] periods_q;
   logic gain_next_q;
   logic last_period;

   assign last_period = cal.conv_done && (periods_q == CAL_PERIODS - 3'h1); // RULE_05

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         state_q <= SEQ_IDLE;
         periods_q <= 3'h0;
         gain_next_q <= 1'b0;
      end else begin
         unique case (state_q)
            SEQ_IDLE: begin
               periods_q <= 3'h0;
               if (cal.start) begin
                  gain_next_q <= cal.do_offset && cal.do_gain;
                  state_q <= cal.do_offset ? SEQ_OFFSET : SEQ_GAIN;
               end
            end
            SEQ_OFFSET: begin
               if (last_period) begin
                  periods_q <= 3'h0;
                  // combined run chains into gain: fourteen periods in all
                  state_q <= gain_next_q ? SEQ_GAIN : SEQ_IDLE; // RULE_05
               end else if (cal.conv_done) begin
                  periods_q <= periods_q + 3'h1;
               end
            end
            SEQ_GAIN: begin
               gain_next_q <= 1'b0;
               if (last_period) begin
                  periods_q <= 3'h0;
                  state_q <= SEQ_IDLE;
               end else if (cal.conv_done) begin
                  periods_q <= periods_q + 3'h1;
               end
            end
         endcase
      end
   end

   assign cal.busy = (state_q != SEQ_IDLE);
   assign cal.phase_gain = (state_q == SEQ_GAIN);
   assign cal.capture = (state_q != SEQ_IDLE) && last_period;
   assign cal.done = last_period && ((state_q == SEQ_GAIN) || !gain_next_q);

endmodule
`default_nettype wire

// >>> verilog/agc_ctrl.sv
// converter front-end control: gain, offset trim, calibration, filter, reference
// assumes sfr strobes, conversion strobes and channel-change pulses are on clock
`timescale 1ns/1ns
`default_nettype none
module agc_ctrl
   import agc_pkg::*;
(
   // clock and reset
   input wire logic clock,
   input wire logic reset_n,
   // special function register bus
   input wire logic [7:0] sfr_addr,
   input wire logic sfr_wr,
   input wire logic sfr_rd,
   input wire logic [7:0] sfr_wdata,
   output logic [7:0] sfr_rdata,
   // converter data path
   input wire logic conv_done,
   input wire logic [23:0] conv_data,
   input wire logic channel_changed,
   output logic result_valid,
   output logic [23:0] result_data,
   // converter interrupt flag
   input wire logic adc_flag_clr,
   output logic adc_flag,
   // analog front-end settings
   output logic [2:0] pga_gain_code,
   output logic buffer_en,
   output logic burnout_en,
   output logic vref_ext_sel,
   output logic vref_int_en,
   output logic vref_high,
   output logic trim_sign,
   output logic [6:0] trim_mag,
   output logic [1:0] cal_input_sel,
   // digital filter and corrections
   output logic [1:0] filter_sel,
   output logic [23:0] ofs_corr,
   output logic [23:0] gain_corr,
   output logic cal_busy
);

   agc_cal_if cal_bus ();

   logic [7:0] ctrl_zero_q;
   logic [1:0] filt_mode_q;
   logic [2:0] cal_cmd_q;
   logic [7:0] trim_q;
   logic [7:0] rdata_q;
   logic flag_q;
   logic [1:0] settle_q;
   logic [1:0] filter_q;
   logic [1:0] cal_in_q;
   logic [23:0] ofs_corr_q;
   logic [23:0] gain_corr_q;
   logic valid_q;
   logic [23:0] result_q;
   logic start_q;
   logic do_ofs_q;
   logic do_gain_q;
   logic system_q;
   logic cal_busy_q;

   logic wr_zero;
   logic wr_one;
   logic wr_trim;
   logic gain_changed;
   logic cmd_legal;
   logic [23:0] corrected;

   assign wr_zero = sfr_wr && (sfr_addr == ADDR_CTRL_ZERO);
   assign wr_one = sfr_wr && (sfr_addr == ADDR_CTRL_ONE);
   assign wr_trim = sfr_wr && (sfr_addr == ADDR_OFFSET_TRIM);
   assign gain_changed = wr_zero &&
      (sfr_wdata[C0_GAIN_LSB +: 3] != ctrl_zero_q[C0_GAIN_LSB +: 3]);

   // reserved codes are not started; they are stored but leave the block idle
   always_comb begin
      unique case (agc_cal_cmd_t'(sfr_wdata[C1_CAL_LSB +: 3]))
         CAL_SELF_BOTH, CAL_SELF_OFS, CAL_SELF_GAIN,
         CAL_SYS_OFS, CAL_SYS_GAIN: cmd_legal = 1'b1;
         CAL_NONE, CAL_RSVD_4, CAL_RSVD_7: cmd_legal = 1'b0;
      endcase
   end

   // converter_control_zero: gain, buffer, burnout, reference controls
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         ctrl_zero_q <= CTRL_ZERO_RESET; // RULE_14
      end else if (wr_zero) begin
         ctrl_zero_q <= sfr_wdata; // RULE_01 RULE_15
      end
   end

   // converter_control_one: filter mode and calibration command
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         filt_mode_q <= FILT_AUTO;
         cal_cmd_q <= CAL_NONE;
      end else begin
         if (wr_one) begin
            filt_mode_q <= sfr_wdata[C1_FILT_LSB +: 2]; // RULE_11
         end
         // a new command is refused while a calibration is running
         if (wr_one && !cal_bus.busy && !start_q) begin
            cal_cmd_q <= sfr_wdata[C1_CAL_LSB +: 3]; // RULE_04
         end else if (cal_bus.done) begin
            cal_cmd_q <= CAL_NONE;
         end
      end
   end

   // offset trim: sign in the top bit, magnitude below
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         trim_q <= OFFSET_TRIM_RESET;
      end else if (wr_trim) begin
         trim_q <= sfr_wdata; // RULE_02
      end
   end

   // calibration launch, decoded once per accepted command
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         start_q <= 1'b0;
         do_ofs_q <= 1'b0;
         do_gain_q <= 1'b0;
         system_q <= 1'b0;
      end else begin
         start_q <= wr_one && !cal_bus.busy && !start_q && cmd_legal; // RULE_04
         if (wr_one && !cal_bus.busy && !start_q) begin
            unique case (agc_cal_cmd_t'(sfr_wdata[C1_CAL_LSB +: 3]))
               CAL_SELF_BOTH: begin
                  do_ofs_q <= 1'b1;
                  do_gain_q <= 1'b1;
                  system_q <= 1'b0;
               end
               CAL_SELF_OFS: begin
                  do_ofs_q <= 1'b1;
                  do_gain_q <= 1'b0;
                  system_q <= 1'b0;
               end
               CAL_SELF_GAIN: begin
                  do_ofs_q <= 1'b0;
                  do_gain_q <= 1'b1;
                  system_q <= 1'b0;
               end
               CAL_SYS_OFS: begin
                  do_ofs_q <= 1'b1;
                  do_gain_q <= 1'b0;
                  system_q <= 1'b1;
               end
               CAL_SYS_GAIN: begin
                  do_ofs_q <= 1'b0;
                  do_gain_q <= 1'b1;
                  system_q <= 1'b1;
               end
               CAL_NONE, CAL_RSVD_4, CAL_RSVD_7: begin
                  do_ofs_q <= 1'b0;
                  do_gain_q <= 1'b0;
                  system_q <= 1'b0;
               end
            endcase
         end
      end
   end

   assign cal_bus.start = start_q;
   assign cal_bus.do_offset = do_ofs_q;
   assign cal_bus.do_gain = do_gain_q;
   assign cal_bus.conv_done = conv_done;

   agc_cal_seq u_seq (
      .clock(clock),
      .reset_n(reset_n),
      .cal(cal_bus.seq)
   );

   // input switches: system runs measure the pins, self runs use internal nodes
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         cal_in_q <= CIN_EXTERNAL;
      end else if (cal_bus.busy && !cal_bus.done && !system_q) begin
         cal_in_q <= cal_bus.phase_gain ? CIN_REFERENCE : CIN_SHORTED;
      end else begin
         cal_in_q <= CIN_EXTERNAL; // RULE_06 RULE_07
      end
   end

   // corrections: last conversion of each phase is the measurement
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         ofs_corr_q <= OFS_CORR_RESET;
         gain_corr_q <= GAIN_CORR_RESET;
      end else if (cal_bus.capture) begin
         if (cal_bus.phase_gain) begin
            // full-scale reading net of offset; back end divides by it
            gain_corr_q <= conv_data + ofs_corr_q; // RULE_07
         end else begin
            // trim offset is measured too, so calibration cancels it
            ofs_corr_q <= 24'h000000 - conv_data; // RULE_06
         end
      end
   end

   // auto filter: count conversions since the last channel or gain change
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         settle_q <= 2'h0;
      end else if (channel_changed || gain_changed) begin
         settle_q <= 2'h0; // RULE_12
      end else if (conv_done && settle_q != 2'h3) begin
         settle_q <= settle_q + 2'h1;
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         filter_q <= FILT_FAST;
      end else if (filt_mode_q != FILT_AUTO) begin
         filter_q <= filt_mode_q; // RULE_11
      end else if (settle_q < AUTO_FAST_CONVS) begin
         filter_q <= FILT_FAST; // RULE_12
      end else if (settle_q == AUTO_FAST_CONVS) begin
         filter_q <= FILT_SINC2;
      end else begin
         filter_q <= FILT_SINC3;
      end
   end

   // normal results are withheld for the whole calibration run
   assign corrected = conv_data + ofs_corr_q;

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         valid_q <= 1'b0;
         result_q <= 24'h000000;
      end else begin
         valid_q <= conv_done && !cal_bus.busy && !start_q; // RULE_17
         if (conv_done && !cal_bus.busy && !start_q) begin
            result_q <= corrected;
         end
      end
   end

   // busy held in a flop: next value of start plus sequencer state, so no gate on the pin
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         cal_busy_q <= 1'b0;
      end else begin
         cal_busy_q <= (wr_one && !cal_bus.busy && !start_q && cmd_legal) || start_q ||
            (cal_bus.busy && !cal_bus.done); // RULE_17
      end
   end

   // shared converter flag: set by results and by calibration end; set wins
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         flag_q <= 1'b0;
      end else if (cal_bus.done) begin
         flag_q <= 1'b1; // RULE_09
      end else if (conv_done && !cal_bus.busy && !start_q) begin
         flag_q <= 1'b1;
      end else if (adc_flag_clr) begin
         flag_q <= 1'b0;
      end
   end

   // read data registered; unmapped addresses read zero
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         rdata_q <= 8'h00;
      end else if (sfr_rd) begin
         unique case (sfr_addr)
            ADDR_CTRL_ZERO: rdata_q <= ctrl_zero_q;
            ADDR_CTRL_ONE: rdata_q <= {cal_bus.busy || start_q, filt_mode_q, 2'h0, cal_cmd_q};
            ADDR_OFFSET_TRIM: rdata_q <= trim_q;
            default: rdata_q <= 8'h00;
         endcase
      end
   end

   // analog settings straight from register flops
   assign pga_gain_code = ctrl_zero_q[C0_GAIN_LSB +: 3]; // RULE_01
   assign buffer_en = ctrl_zero_q[C0_BUFFER_BIT];
   assign burnout_en = ctrl_zero_q[C0_BURNOUT_BIT];
   assign vref_ext_sel = ctrl_zero_q[C0_REF_EXT_BIT]; // RULE_14
   assign vref_int_en = ctrl_zero_q[C0_REF_INT_EN_BIT];
   assign vref_high = ctrl_zero_q[C0_REF_HIGH_BIT]; // RULE_15
   // the analog trim step is sized so TRIM_HALF_RANGE_MAG is half input range
   assign trim_sign = trim_q[TRIM_SIGN_BIT]; // RULE_02
   assign trim_mag = trim_q[6:0]; // RULE_03

   assign sfr_rdata = rdata_q;
   assign result_valid = valid_q;
   assign result_data = result_q;
   assign adc_flag = flag_q;
   assign cal_input_sel = cal_in_q;
   assign filter_sel = filter_q;
   assign ofs_corr = ofs_corr_q;
   assign gain_corr = gain_corr_q;
   assign cal_busy = cal_busy_q;

endmodule
`default_nettype wire

// >>> dv/agc_ctrl_props.sv
// concurrent checks on the converter front-end control ports
// assumes it is bound to agc_ctrl and sees only its ports
`timescale 1ns/1ns
`default_nettype none
module agc_ctrl_props
   import agc_pkg::*;
(
   // clock and reset
   input wire logic clock,
   input wire logic reset_n,
   // register bus
   input wire logic [7:0] sfr_addr,
   input wire logic sfr_wr,
   input wire logic [7:0] sfr_wdata,
   // converter path
   input wire logic conv_done,
   input wire logic [23:0] conv_data,
   input wire logic result_valid,
   input wire logic [23:0] result_data,
   input wire logic adc_flag_clr,
   input wire logic adc_flag,
   // settings
   input wire logic [2:0] pga_gain_code,
   input wire logic vref_ext_sel,
   input wire logic vref_int_en,
   input wire logic vref_high,
   input wire logic trim_sign,
   input wire logic [6:0] trim_mag,
   input wire logic [23:0] ofs_corr,
   input wire logic cal_busy
);
   default clocking @(posedge clock); endclocking
   default disable iff (!reset_n);
   // conversions seen in one calibration; cleared while idle
   logic [4:0] cnt_q;
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n)
         cnt_q <= 5'h00;
      else if (!cal_busy)
         cnt_q <= 5'h00;
      else if (conv_done)
         cnt_q <= cnt_q + 5'h01;
   end
   sequence s_wr(logic [7:0] a);
      sfr_wr && sfr_addr == a;
   endsequence
   sequence s_cal_wr;
      s_wr(ADDR_CTRL_ONE) ##0 !cal_busy;
   endsequence
   a_gain_write: assert property (s_wr(ADDR_CTRL_ZERO) |=>
      pga_gain_code == $past(sfr_wdata[2:0])) else $error("gain code not taken");
   a_trim_write: assert property (s_wr(ADDR_OFFSET_TRIM) |=>
      {trim_sign, trim_mag} == $past(sfr_wdata)) else $error("offset trim not taken");
   a_ref_write: assert property (s_wr(ADDR_CTRL_ZERO) |=>
      {vref_ext_sel, vref_int_en, vref_high} ==
      {$past(sfr_wdata[7]), $past(sfr_wdata[5]), $past(sfr_wdata[4])})
      else $error("reference controls not taken");
   a_cal_start: assert property (s_cal_wr ##0
      sfr_wdata[2:0] inside {3'h1, 3'h2, 3'h3, 3'h5, 3'h6} |=> cal_busy)
      else $error("calibration did not start");
   a_cal_idle: assert property (s_cal_wr ##0
      sfr_wdata[2:0] inside {3'h0, 3'h4, 3'h7} |=> !cal_busy)
      else $error("idle code started calibration");
   a_cal_periods: assert property ($fell(cal_busy) |->
      cnt_q == 5'h07 || cnt_q == 5'h0E) else $error("calibration length wrong");
   a_done_flag: assert property ($fell(cal_busy) |-> adc_flag)
      else $error("flag missing at calibration end");
   a_flag_sticky: assert property (adc_flag && !adc_flag_clr |=> adc_flag)
      else $error("flag dropped without clear");
   a_no_result: assert property (result_valid |->
      $past(conv_done) && !$past(cal_busy)) else $error("result during calibration");
   a_result_path: assert property (conv_done && !cal_busy |=> result_valid &&
      result_data == $past(conv_data) + $past(ofs_corr)) else $error("result wrong");
endmodule
bind agc_ctrl agc_ctrl_props u_props (.clock, .reset_n, .sfr_addr, .sfr_wr, .sfr_wdata,
   .conv_done, .conv_data, .result_valid, .result_data, .adc_flag_clr, .adc_flag,
   .pga_gain_code, .vref_ext_sel, .vref_int_en, .vref_high, .trim_sign, .trim_mag,
   .ofs_corr, .cal_busy);
`default_nettype wire

// >>> dv/testbench.sv
// self-checking bench for the converter front-end control block
// assumes one 20 MHz clock; the bench drives every port itself
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e, m) begin samples_checked++; if ((a) !== (e)) begin error_cnt++; \
   $display("CHECK FAILED t=%0t %s", $time, m); end end
module testbench
   import agc_pkg::*;
;
   logic clock, reset_n, sfr_wr, sfr_rd, conv_done, channel_changed, adc_flag_clr;
   logic [7:0] sfr_addr, sfr_wdata, sfr_rdata;
   logic [23:0] conv_data, result_data, ofs_corr, gain_corr;
   logic result_valid, adc_flag, buffer_en, burnout_en, vref_ext_sel, vref_int_en;
   logic vref_high, trim_sign, cal_busy;
   logic [2:0] pga_gain_code;
   logic [6:0] trim_mag;
   logic [1:0] cal_input_sel, filter_sel;
   int error_cnt = 0;
   int samples_checked = 0;
   int cyc = 0;
   int n_res = 0;

   agc_ctrl DUT (.clock, .reset_n, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata,
      .conv_done, .conv_data, .channel_changed, .result_valid, .result_data,
      .adc_flag_clr, .adc_flag, .pga_gain_code, .buffer_en, .burnout_en, .vref_ext_sel,
      .vref_int_en, .vref_high, .trim_sign, .trim_mag, .cal_input_sel, .filter_sel,
      .ofs_corr, .gain_corr, .cal_busy);

   initial begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end
   // run is a few hundred cycles; the ceiling leaves wide margin
   always @(posedge clock) begin
      cyc++;
      if (result_valid)
         n_res++;
      if (cyc == 20000) begin
         error_cnt++;
         end_sim;
      end
   end

   task automatic end_sim;
      $display("checks %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic tick;
      @(posedge clock);
      #2;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      sfr_addr = a;
      sfr_wdata = d;
      sfr_wr = 1'b1;
      tick;
      sfr_wr = 1'b0;
      tick;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e, input string m);
      sfr_addr = a;
      sfr_rd = 1'b1;
      tick;
      sfr_rd = 1'b0;
      `CHK(sfr_rdata, e, m)
      tick;
   endtask
   task automatic conv(input logic [23:0] d);
      conv_data = d;
      conv_done = 1'b1;
      tick;
      conv_done = 1'b0;
      tick;
      tick;
   endtask
   task automatic clr;
      adc_flag_clr = 1'b1;
      tick;
      adc_flag_clr = 1'b0;
      tick;
   endtask
   // first conversion falls two edges after the command write
   task automatic cal(input logic [2:0] c, input int n, input logic [1:0] sel,
         input logic [23:0] d1, input logic [23:0] d2);
      int r;
      r = n_res;
      clr;
      wr(ADDR_CTRL_ONE, {5'h00, c});
      for (int i = 0; i < n; i++) begin
         if (i == n - 1) begin
            `CHK(cal_busy, 1'b1, "busy before last period")
            `CHK(adc_flag, 1'b0, "flag early")
         end
         conv((i < 7) ? d1 : d2);
         if (i == 0) begin
            `CHK(cal_input_sel, sel, "calibration input")
            wr(ADDR_CTRL_ONE, 8'h06);
            rd(ADDR_CTRL_ONE, {5'h10, c}, "command refused while busy");
         end
      end
      `CHK(cal_busy, 1'b0, "busy after last period")
      `CHK(adc_flag, 1'b1, "completion flag")
      `CHK(n_res, r, "results during calibration")
      rd(ADDR_CTRL_ONE, 8'h00, "command cleared");
   endtask

   initial begin
      reset_n = 1'b0;
      sfr_wr = 1'b0;
      sfr_rd = 1'b0;
      sfr_addr = 8'h00;
      sfr_wdata = 8'h00;
      conv_done = 1'b0;
      conv_data = 24'h000000;
      channel_changed = 1'b0;
      adc_flag_clr = 1'b0;
      repeat (20) @(posedge clock);
      #2;
      reset_n = 1'b1;
      rd(ADDR_CTRL_ZERO, CTRL_ZERO_RESET, "control zero reset");
      rd(ADDR_CTRL_ONE, 8'h00, "control one reset");
      rd(ADDR_OFFSET_TRIM, 8'h00, "trim reset");
      rd(8'h80, 8'h00, "unmapped read");
      `CHK(filter_sel, FILT_FAST, "filter reset")
      $display("test reset done");
      for (int i = 0; i < 8; i++) begin
         wr(ADDR_CTRL_ZERO, 8'h30 | 8'(i));
         `CHK(pga_gain_code, 3'(i), "gain code")
      end
      rd(ADDR_CTRL_ZERO, 8'h37, "gain read back");
      wr(ADDR_CTRL_ZERO, 8'h80);
      `CHK({vref_ext_sel, vref_int_en}, 2'h2, "external reference")
      wr(ADDR_CTRL_ZERO, 8'h20);
      `CHK({vref_int_en, vref_high}, 2'h2, "low internal level")
      wr(ADDR_CTRL_ZERO, 8'h48);
      `CHK({buffer_en, burnout_en, vref_int_en}, 3'h6, "buffer and burnout")
      wr(ADDR_CTRL_ZERO, 8'h30);
      `CHK(vref_high, 1'b1, "high internal level")
      wr(ADDR_OFFSET_TRIM, 8'h85);
      `CHK({trim_sign, trim_mag}, 8'h85, "negative trim")
      wr(ADDR_OFFSET_TRIM, 8'h7F);
      `CHK(trim_mag, TRIM_HALF_RANGE_MAG, "full trim magnitude")
      `CHK(trim_sign, 1'b0, "positive trim")
      wr(8'h81, 8'hFF);
      rd(ADDR_CTRL_ZERO, 8'h30, "unmapped write ignored");
      $display("test settings done");
      for (int f = 1; f < 4; f++) begin
         wr(ADDR_CTRL_ONE, 8'(f << 5));
         `CHK(filter_sel, 2'(f), "fixed filter")
      end
      wr(ADDR_CTRL_ONE, 8'h00);
      channel_changed = 1'b1;
      tick;
      channel_changed = 1'b0;
      tick;
      `CHK(filter_sel, FILT_FAST, "auto first")
      conv(24'h000100);
      `CHK(filter_sel, FILT_FAST, "auto second")
      conv(24'h000100);
      `CHK(filter_sel, FILT_SINC2, "auto third")
      conv(24'h000100);
      `CHK(filter_sel, FILT_SINC3, "auto settled")
      wr(ADDR_CTRL_ZERO, 8'h31);
      `CHK(filter_sel, FILT_FAST, "auto after gain change")
      wr(ADDR_CTRL_ZERO, 8'h30);
      $display("test filter done");
      cal(3'h2, 7, 2'h1, 24'h000010, 24'h000000);
      `CHK(ofs_corr, 24'hFFFFF0, "self offset")
      cal(3'h3, 7, 2'h2, 24'h200000, 24'h000000);
      cal(3'h5, 7, 2'h0, 24'h000020, 24'h000000);
      `CHK(ofs_corr, 24'hFFFFE0, "system offset")
      cal(3'h1, 14, 2'h1, 24'h000008, 24'h400008);
      `CHK(ofs_corr, 24'hFFFFF8, "combined offset")
      `CHK(gain_corr, 24'h400000, "combined gain")
      cal(3'h6, 7, 2'h0, 24'h300008, 24'h000000);
      `CHK(gain_corr, 24'h300000, "system gain")
      for (int c = 4; c < 8; c += 3) begin
         wr(ADDR_CTRL_ONE, 8'(c));
         `CHK(cal_busy, 1'b0, "reserved command")
      end
      rd(ADDR_CTRL_ONE, 8'h07, "reserved code stored");
      wr(ADDR_CTRL_ONE, 8'h00);
      $display("test calibration done");
      wr(ADDR_OFFSET_TRIM, 8'h05);
      clr;
      conv_data = 24'h000100;
      conv_done = 1'b1;
      tick;
      conv_done = 1'b0;
      `CHK(result_valid, 1'b1, "result pulse")
      `CHK(result_data, 24'h0000F8, "corrected result")
      `CHK(adc_flag, 1'b1, "result flag")
      tick;
      `CHK(result_valid, 1'b0, "pulse width")
      clr;
      `CHK(adc_flag, 1'b0, "flag cleared")
      $display("test result done");
      end_sim;
   end
endmodule
`default_nettype wire
